//--- core/ssw_pkg.sv
// Constants and timing figures for the supply supervisor and watchdog
// Contract
// - While supply-good is low the reset output stays asserted.
// - After supply-good rises, reset holds one reset timeout, then ends.
// - With no kick edge before the watchdog timeout, the fault asserts.
// - The fault output is one pulse per timeout, 100 to 300 ms wide.
// - An externally driven manual reset input produces a reset pulse.
// - The watchdog enable input switches the watchdog on and off.
// - After enable rises the watchdog waits about 300 us before start.
// - The watchdog timer clears on reset release and on a kick fall.
// - The watchdog timer runs only while the enable input is high.
// - The system reset output is active low.
package ssw_pkg;
  localparam int CLK_HZ           = 100_000_000;
  localparam int TICK_HZ          = 1_000;
  localparam int TICK_DIV         = CLK_HZ / TICK_HZ;
  localparam int RESET_TIMEOUT_MS = 200;
  localparam int WD_TIMEOUT_MS    = 1600;
  localparam int FAULT_WIDTH_MS   = 200;
  localparam int FAULT_MIN_MS     = 100;
  localparam int FAULT_MAX_MS     = 300;
  localparam int SETUP_US         = 300;
  localparam int SETUP_CYCLES     = SETUP_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W            = 20;
  localparam logic RST_N_INIT     = 1'b0;
  localparam logic FAULT_N_INIT   = 1'b1;
endpackage

//--- core/ssw_sync.sv
// Two-stage synchroniser for asynchronous pin levels
module ssw_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

//--- core/ssw_top.sv
// Supply supervisor with reset timeout, watchdog and fault pulse
module ssw_top
  import ssw_pkg::*;
#(
  // Interval lengths in ticks; TICK_DIVIDE and SETUP_CLKS in clock cycles
  parameter int TICK_DIVIDE   = ssw_pkg::TICK_DIV,
  parameter int RESET_TICKS   = ssw_pkg::RESET_TIMEOUT_MS,
  parameter int WD_TICKS      = ssw_pkg::WD_TIMEOUT_MS,
  parameter int FAULT_TICKS   = ssw_pkg::FAULT_WIDTH_MS,
  parameter int SETUP_CLKS    = ssw_pkg::SETUP_CYCLES
) (
  clk,
  rst,
  supply_good_in,
  manual_reset_n_in,
  watchdog_enable_in,
  watchdog_kick_in,
  sys_reset_n_out,
  watchdog_fault_n_out
);
  input  wire logic clk;
  input  wire logic rst;
  input  wire logic supply_good_in;
  input  wire logic manual_reset_n_in;
  input  wire logic watchdog_enable_in;
  input  wire logic watchdog_kick_in;
  output logic      sys_reset_n_out;
  output logic      watchdog_fault_n_out;

  // Refuse settings that the counters cannot hold
  if (TICK_DIVIDE < 1 || RESET_TICKS < 1 || WD_TICKS < 2 ||
      FAULT_TICKS < 1 || SETUP_CLKS < 1 ||
      TICK_DIVIDE >= (1 << CNT_W) || WD_TICKS >= (1 << CNT_W) ||
      RESET_TICKS >= (1 << CNT_W) || FAULT_TICKS >= (1 << CNT_W) ||
      SETUP_CLKS >= (1 << CNT_W)) begin : g_param_check
    $error("ssw_top: parameter out of range");
  end

  // Every pin input except clk and rst crosses two flops before any logic reads it
  logic good_s, mr_n_s, en_s, kick_s;
  ssw_sync #(.INIT(1'b0)) u_good (
    .clk (clk),
    .rst (rst),
    .d   (supply_good_in),
    .q   (good_s)
  );
  ssw_sync #(.INIT(1'b1)) u_mr (
    .clk (clk),
    .rst (rst),
    .d   (manual_reset_n_in),
    .q   (mr_n_s)
  );
  ssw_sync #(.INIT(1'b0)) u_en (
    .clk (clk),
    .rst (rst),
    .d   (watchdog_enable_in),
    .q   (en_s)
  );
  ssw_sync #(.INIT(1'b0)) u_kick (
    .clk (clk),
    .rst (rst),
    .d   (watchdog_kick_in),
    .q   (kick_s)
  );

  // Millisecond tick divider
  logic [CNT_W-1:0] div_reg;
  wire              tick = (div_reg == CNT_W'(TICK_DIVIDE - 1));
  always_ff @(posedge clk) begin
    if (rst)       div_reg <= '0;
    else if (tick) div_reg <= '0;
    else           div_reg <= div_reg + 1'b1;
  end
  chk_div_wrap: assert property (@(posedge clk) disable iff (rst)
    tick |=> div_reg == '0)
    else $error("tick divider did not wrap");

  // Reset hold: asserted while supply low or manual reset, then timeout
  logic [CNT_W-1:0] rp_reg;
  wire hold_cond = !good_s || !mr_n_s;
  wire rp_done   = (rp_reg == CNT_W'(RESET_TICKS));
  always_ff @(posedge clk) begin
    if (rst || hold_cond)      rp_reg <= '0;
    else if (tick && !rp_done) rp_reg <= rp_reg + 1'b1;
  end
  wire rst_n_next = rp_done && !hold_cond;
  always_ff @(posedge clk) begin
    if (rst) sys_reset_n_out <= RST_N_INIT;
    else     sys_reset_n_out <= rst_n_next;
  end
  chk_hold_clear: assert property (@(posedge clk) disable iff (rst)
    hold_cond |=> rp_reg == '0)
    else $error("reset timeout not restarted");
  chk_count_hold: assert property (@(posedge clk) disable iff (rst)
    !hold_cond && !rp_done |=> !sys_reset_n_out)
    else $error("reset released before timeout");
  chk_release_out: assert property (@(posedge clk) disable iff (rst)
    rp_done && !hold_cond |=> sys_reset_n_out)
    else $error("reset not released after timeout");

  // Watchdog enable setup delay
  logic [CNT_W-1:0] setup_reg;
  logic             en_d_reg;
  wire en_rise  = en_s && !en_d_reg;
  wire wd_armed = en_s && (setup_reg == CNT_W'(SETUP_CLKS));
  always_ff @(posedge clk) begin
    if (rst) begin
      en_d_reg  <= 1'b0;
      setup_reg <= '0;
    end else begin
      en_d_reg <= en_s;
      if (!en_s || en_rise)
        setup_reg <= '0;
      else if (!wd_armed)
        setup_reg <= setup_reg + 1'b1;
    end
  end
  chk_setup_clear: assert property (@(posedge clk) disable iff (rst)
    en_rise |=> setup_reg == '0)
    else $error("setup interval not restarted");

  // Watchdog timer
  logic             kick_d_reg;
  logic             rst_n_d_reg;
  logic [CNT_W-1:0] wd_reg;
  logic [CNT_W-1:0] fault_reg;
  wire kick_fall  = kick_d_reg && !kick_s;
  wire rst_deass  = sys_reset_n_out && !rst_n_d_reg;
  wire in_fault   = (fault_reg != '0);
  wire wd_expire  = wd_armed && sys_reset_n_out && !in_fault && tick &&
                    (wd_reg == CNT_W'(WD_TICKS - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      kick_d_reg  <= 1'b0;
      rst_n_d_reg <= 1'b0;
      wd_reg      <= '0;
    end else begin
      kick_d_reg  <= kick_s;
      rst_n_d_reg <= sys_reset_n_out;
      if (!wd_armed || rst_deass || kick_fall || wd_expire)
        wd_reg <= '0;
      else if (tick && sys_reset_n_out && !in_fault)
        wd_reg <= wd_reg + 1'b1;
    end
  end
  chk_release_clr: assert property (@(posedge clk) disable iff (rst)
    rst_deass |=> wd_reg == '0)
    else $error("reset release did not clear timer");
  chk_timer_frozen: assert property (@(posedge clk) disable iff (rst)
    in_fault && wd_armed && !kick_fall && !rst_deass
      |=> $stable(wd_reg))
    else $error("timer ran during fault pulse");
  chk_tick_step: assert property (@(posedge clk) disable iff (rst)
    !tick && wd_armed && !kick_fall && !rst_deass
      |=> $stable(wd_reg))
    else $error("timer moved between ticks");

  // Fault pulse of fixed width
  always_ff @(posedge clk) begin
    if (rst)                   fault_reg <= '0;
    else if (wd_expire)        fault_reg <= CNT_W'(FAULT_TICKS);
    else if (tick && in_fault) fault_reg <= fault_reg - 1'b1;
  end
  // Output ends on the tick that empties the width counter
  wire fault_last   = tick && (fault_reg == CNT_W'(1));
  wire fault_n_next = !(wd_expire || (in_fault && !fault_last));
  always_ff @(posedge clk) begin
    if (rst) watchdog_fault_n_out <= FAULT_N_INIT;
    else     watchdog_fault_n_out <= fault_n_next;
  end
  chk_fault_once: assert property (@(posedge clk) disable iff (rst)
    $rose(watchdog_fault_n_out) |=> watchdog_fault_n_out)
    else $error("fault pulse restarted at once");

  // Checks
  sequence s_good_back;
    $rose(good_s) && mr_n_s;
  endsequence
  chk_low_supply: assert property (@(posedge clk) disable iff (rst)
    !good_s |=> !sys_reset_n_out)
    else $error("reset released while supply low");
  chk_hold_time: assert property (@(posedge clk) disable iff (rst)
    s_good_back |=> !sys_reset_n_out [*8])
    else $error("reset released too early");
  chk_manual_rst: assert property (@(posedge clk) disable iff (rst)
    !mr_n_s |=> !sys_reset_n_out)
    else $error("manual reset ignored");
  chk_fault_cause: assert property (@(posedge clk) disable iff (rst)
    $fell(watchdog_fault_n_out) |-> $past(wd_expire))
    else $error("fault without timeout");
  chk_fault_width: assert property (@(posedge clk) disable iff (rst)
    $fell(watchdog_fault_n_out) |=> !watchdog_fault_n_out [*8])
    else $error("fault pulse too short");
  chk_en_off: assert property (@(posedge clk) disable iff (rst)
    !en_s |=> !wd_armed && wd_reg == '0)
    else $error("watchdog runs while disabled");
  chk_setup_wait: assert property (@(posedge clk) disable iff (rst)
    en_rise |-> !wd_armed [*8])
    else $error("watchdog armed before setup");
  chk_kick_clear: assert property (@(posedge clk) disable iff (rst)
    kick_fall |=> wd_reg == '0)
    else $error("kick did not clear timer");
  chk_fault_enable: assert property (@(posedge clk) disable iff (rst)
    !en_s && !in_fault |=> watchdog_fault_n_out)
    else $error("timeout while disabled");
endmodule

//--- tb/ssw_kick_model.sv
// Processor model that services the watchdog kick input
module ssw_kick_model (
  input  wire logic clk,
  input  wire logic active,
  output logic      kick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial kick = 1'h0;
  // Toggles every 20 cycles, so falls well inside the timeout
  always @(posedge clk) begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    if (active && cnt == 19) kick <= #1 ~kick;
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the supply supervisor and watchdog
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, good = 1'h0, mr_n = 1'h1, en = 1'h0;
  logic kick_on = 1'h0;
  logic kick, rst_n, fault_n;
  int   mismatches = 0, total_checks = 0;
  initial forever #5 clk = ~clk;
  ssw_kick_model KICK (.clk(clk), .active(kick_on), .kick(kick));
  ssw_top #(.TICK_DIVIDE(4), .RESET_TICKS(10), .WD_TICKS(20),
    .FAULT_TICKS(10), .SETUP_CLKS(12)) DUT (.clk(clk), .rst(rst),
    .supply_good_in(good), .manual_reset_n_in(mr_n),
    .watchdog_enable_in(en), .watchdog_kick_in(kick),
    .sys_reset_n_out(rst_n), .watchdog_fault_n_out(fault_n));
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Cycles until the fault output goes low, capped at lim
  task automatic wait_fault(input int lim, output int n);
    n = 0;
    while (fault_n !== 1'h0 && n < lim) begin cyc(1); n++; end
  endtask
  task automatic t_supply;
    en = 1'h1;
    kick_on = 1'h1;
    cyc(60);
    chk_bit(rst_n, 1'h0);
    good = 1'h1;
    cyc(30);
    chk_bit(rst_n, 1'h0);
    cyc(25);
    chk_bit(rst_n, 1'h1);
  endtask
  task automatic t_kick;
    int lows = 0;
    repeat (300) begin cyc(1); if (fault_n !== 1'h1) lows++; end
    chk_num(lows, 0);
  endtask
  task automatic t_timeout;
    int n, w = 0;
    kick_on = 1'h0;
    wait_fault(200, n);
    chk_bit(fault_n, 1'h0);
    chk_num(n > 30, 1);
    while (fault_n === 1'h0 && w < 100) begin cyc(1); w++; end
    chk_num(w, 40);
    cyc(20);
    chk_bit(fault_n, 1'h1);
  endtask
  task automatic t_enable;
    int n;
    kick_on = 1'h1;
    cyc(100);
    en = 1'h0;
    kick_on = 1'h0;
    wait_fault(300, n);
    chk_num(n, 300);
    en = 1'h1;
    wait_fault(300, n);
    chk_num(n > 84, 1);
    chk_bit(fault_n, 1'h0);
  endtask
  task automatic t_manual;
    chk_bit(rst_n, 1'h1);
    mr_n = 1'h0;
    cyc(6);
    chk_bit(rst_n, 1'h0);
    mr_n = 1'h1;
    cyc(60);
    chk_bit(rst_n, 1'h1);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50us;
    mismatches++;
    complete_run();
  end
  initial begin
    cyc(20);
    rst = 1'h0;
    t_supply();
    t_kick();
    t_timeout();
    t_enable();
    t_manual();
    complete_run();
  end
endmodule
